/* rtl/tsiu_pkg.sv */
/*
  Package of the twelve-source interrupt unit: register indices, field
  positions, reset values, vector table and service order.
  Assumes a word-addressed Avalon-MM slave whose address is the register index.
*/
package tsiu_pkg;

  // ------------------------------------------------------------------------
  // Register indices (word addresses on the bus)
  // ------------------------------------------------------------------------
  localparam logic [7:0] IDX_POWER_CONTROL  = 8'h87;
  localparam logic [7:0] IDX_SOURCE_ENABLES = 8'ha8;
  localparam logic [7:0] IDX_PRIO_LOW       = 8'hb8;
  localparam logic [7:0] IDX_PORT_FLAGS     = 8'hc0;
  localparam logic [7:0] IDX_EVENT_STATUS   = 8'hd0;
  localparam logic [7:0] IDX_EVENT_MASK     = 8'hd1;
  localparam logic [7:0] IDX_PORT_ENABLES   = 8'he8;
  localparam logic [7:0] IDX_PORT_POLARITY  = 8'he9;
  localparam logic [7:0] IDX_PRIO_HIGH      = 8'hf8;

  // ------------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------------
  localparam int BIT_EXT_ZERO    = 0;   // Shared by enable and low priority
  localparam int BIT_TIMER_ZERO  = 1;
  localparam int BIT_EXT_ONE     = 2;
  localparam int BIT_TIMER_ONE   = 3;
  localparam int BIT_GLOBAL_EN   = 7;
  localparam int BIT_IDLE_REQ    = 0;   // Power control register
  localparam int BIT_PDOWN_REQ   = 1;
  localparam int BIT_EV_ACCEPT   = 0;   // Event status and mask
  localparam int BIT_EV_WAKE     = 1;
  localparam int BIT_EV_IDLE_END = 2;

  // ------------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------------
  localparam logic [7:0] RST_REG8 = 8'h00;

  // ------------------------------------------------------------------------
  // Sources in service order, index 0 served first
  // ------------------------------------------------------------------------
  localparam int NUM_SRC = 12;
  localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
    16'h0003, 16'h0053, 16'h000b, 16'h005b, 16'h0013, 16'h003b,
    16'h0063, 16'h001b, 16'h0043, 16'h006b, 16'h004b, 16'h0073};

  // Handshake toward the core
  typedef struct packed {
    logic        valid;
    logic        high_level;
    logic [15:0] vector;
  } tsiu_core_req_s;

endpackage : tsiu_pkg

/* rtl/tsiu_sync.sv */
/*
  Two flip-flop synchroniser, any width.
  Assumes inputs come from outside the mclk_i domain, one bit independent of the next.
*/
`timescale 1ns/100ps
`default_nettype none

module tsiu_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             srst_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // First stage feeds only the second
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule : tsiu_sync

`default_nettype wire

/* rtl/tsiu_top.sv */
/*
  Twelve-source two-level interrupt unit with Avalon-MM register slave.
  Assumes the core pulses core_ack_i when it takes the offered vector and
  ret_i when a service routine returns; legacy flags arrive on mclk_i.
*/
// What this block does
// - Twelve sources, each with its own fixed vector, 0003H through 0073H.
// - Each source requests only while its own enable bit is one.
// - Global enable gates every source; cleared means nothing is serviced.
// - Port enable register bits 7..0 enable port interrupts nine down to two.
// - One priority bit per source; one puts it on the high level.
// - High priority register bits 7..0 hold ports nine down to two.
// - Port interrupts two to nine are level detected.
// - Polarity bit zero means active low, one means active high.
// - Port flags set by hardware, cleared only by a software write.
// - A flag still set after return raises the same interrupt again.
// - Port flag register bits 7..0 hold ports nine down to two.
// - Same-level ties follow the fixed twelve-entry service order.
// - In power-down an enabled port request wakes the device.
// - Interrupt logic stays clocked in idle; a serviced interrupt ends idle.
// - Enable, priority, polarity and flag registers reset to zero.
`timescale 1ns/100ps
`default_nettype none

module tsiu_top (
  // Clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    srst_i,
  // Avalon-MM slave
  input  wire logic [7:0]              avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  output logic      [31:0]             avs_readdata_o,
  output logic                         avs_waitrequest_o,
  // Interrupt sources
  input  wire logic                    ext_zero_pending_i,
  input  wire logic                    ext_request_one_i,
  input  wire logic                    timer_zero_overflow_i,
  input  wire logic                    timer_one_overflow_i,
  input  wire logic [7:0]              port_pin_i,
  // Core handshake
  output tsiu_pkg::tsiu_core_req_s     core_req_o,
  input  wire logic                    core_ack_i,
  input  wire logic                    ret_i,
  // Power and system interrupt
  output logic                         idle_o,
  output logic                         powerdown_o,
  output logic                         wake_o,
  output logic                         irq_o
);

  import tsiu_pkg::*;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0]     src_en_r;
  logic [7:0]     port_en_r;
  logic [7:0]     prio_lo_r;
  logic [7:0]     prio_hi_r;
  logic [7:0]     polarity_r;
  logic [7:0]     flags_r;
  logic [7:0]     flags_nxt;
  logic [1:0]     power_r;
  logic [1:0]     power_nxt;
  logic [2:0]     ev_stat_r;
  logic [2:0]     ev_stat_nxt;
  logic [2:0]     ev_mask_r;
  logic           bus_ack_r;
  logic [31:0]    rdata_r;
  logic           svc_low_r;
  logic           svc_high_r;
  tsiu_core_req_s req_r;
  tsiu_core_req_s req_nxt;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  // One wait state: read data are captured on the same edge at which waitrequest drops
  wire        bus_req   = avs_read_i | avs_write_i;
  wire        wr_en     = avs_write_i & bus_ack_r;
  wire [7:0]  wdata     = avs_writedata_i[7:0];
  wire        wr_src    = wr_en & (avs_address_i == IDX_SOURCE_ENABLES);
  wire        wr_port   = wr_en & (avs_address_i == IDX_PORT_ENABLES);
  wire        wr_plo    = wr_en & (avs_address_i == IDX_PRIO_LOW);
  wire        wr_phi    = wr_en & (avs_address_i == IDX_PRIO_HIGH);
  wire        wr_pol    = wr_en & (avs_address_i == IDX_PORT_POLARITY);
  wire        wr_flag   = wr_en & (avs_address_i == IDX_PORT_FLAGS);
  wire        wr_pwr    = wr_en & (avs_address_i == IDX_POWER_CONTROL);
  wire        wr_evs    = wr_en & (avs_address_i == IDX_EVENT_STATUS);
  wire        wr_evm    = wr_en & (avs_address_i == IDX_EVENT_MASK);

  assign avs_waitrequest_o = bus_req & ~bus_ack_r;
  assign avs_readdata_o    = rdata_r;

  // Read multiplexer; unmapped indices read as zero
  logic [7:0] rd_sel;
  always_comb
  begin
    case (avs_address_i)
      IDX_SOURCE_ENABLES: rd_sel = src_en_r;
      IDX_PORT_ENABLES:   rd_sel = port_en_r;
      IDX_PRIO_LOW:       rd_sel = prio_lo_r;
      IDX_PRIO_HIGH:      rd_sel = prio_hi_r;
      IDX_PORT_POLARITY:  rd_sel = polarity_r;
      IDX_PORT_FLAGS:     rd_sel = flags_r;
      IDX_POWER_CONTROL:  rd_sel = {6'h00, power_r};
      IDX_EVENT_STATUS:   rd_sel = {5'h00, ev_stat_r};
      IDX_EVENT_MASK:     rd_sel = {5'h00, ev_mask_r};
      default:            rd_sel = 8'h00;
    endcase
  end

  // Bus handshake state
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      bus_ack_r <= 1'b0;
      rdata_r   <= 32'h0000_0000;
    end
    else
    begin
      bus_ack_r <= bus_req & ~bus_ack_r;
      rdata_r   <= {24'h00_0000, rd_sel};
    end
  end

  // --------------------------------------------------------------------------
  // Port inputs: synchronise, then apply polarity
  // --------------------------------------------------------------------------
  logic [7:0] pin_sync;
  logic [1:0] sync_fill_r;

  tsiu_sync #(
    .WIDTH  (8)
  ) u_pin_sync (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .async_i(port_pin_i),
    .sync_o (pin_sync)
  );

  // Synchroniser holds reset zeros for two edges; with active-low polarity
  // those would read as live requests and set every flag straight after reset
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      sync_fill_r <= 2'h0;
    else
      sync_fill_r <= {sync_fill_r[0], 1'b1};
  end

  wire       sync_live   = sync_fill_r[1];

  // Active when the pin equals its polarity bit; no edge is needed
  wire [7:0] port_active = ~(pin_sync ^ polarity_r) & {8{sync_live}};

  // Flags: software write stores, a live request always wins over the clear
  assign flags_nxt = (wr_flag ? wdata : flags_r) | port_active;

  // --------------------------------------------------------------------------
  // Source gathering in service order
  // --------------------------------------------------------------------------
  // Port bit k-2 is port k; order ext0,p5,t0,p6,ext1,p2,p7,t1,p3,p8,p4,p9
  wire [NUM_SRC-1:0] src_req = {flags_r[7], flags_r[2], flags_r[6], flags_r[1],
                                timer_one_overflow_i, flags_r[5], flags_r[0], ext_request_one_i,
                                flags_r[4], timer_zero_overflow_i, flags_r[3],
                                ext_zero_pending_i};
  wire [NUM_SRC-1:0] src_en  = {port_en_r[7], port_en_r[2], port_en_r[6], port_en_r[1],
                                src_en_r[BIT_TIMER_ONE], port_en_r[5], port_en_r[0],
                                src_en_r[BIT_EXT_ONE], port_en_r[4], src_en_r[BIT_TIMER_ZERO],
                                port_en_r[3], src_en_r[BIT_EXT_ZERO]};
  wire [NUM_SRC-1:0] src_hi  = {prio_hi_r[7], prio_hi_r[2], prio_hi_r[6], prio_hi_r[1],
                                prio_lo_r[BIT_TIMER_ONE], prio_hi_r[5], prio_hi_r[0],
                                prio_lo_r[BIT_EXT_ONE], prio_hi_r[4], prio_lo_r[BIT_TIMER_ZERO],
                                prio_hi_r[3], prio_lo_r[BIT_EXT_ZERO]};

  // Eligible only with own enable and the global enable
  wire [NUM_SRC-1:0] elig    = src_req & src_en & {NUM_SRC{src_en_r[BIT_GLOBAL_EN]}};
  wire [NUM_SRC-1:0] elig_hi = elig & src_hi;
  wire [NUM_SRC-1:0] elig_lo = elig & ~src_hi;

  // High may interrupt low service; low only when nothing is in service
  wire take_hi  = (|elig_hi) & ~svc_high_r;
  wire take_lo  = (|elig_lo) & ~svc_high_r & ~svc_low_r;
  wire [NUM_SRC-1:0] pick_set = take_hi ? elig_hi : elig_lo;

  // Lowest index wins among the chosen level
  logic [15:0] pick_vec;
  always_comb
  begin
    pick_vec = VEC_TABLE[0];
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (pick_set[i])
      begin
        pick_vec = VEC_TABLE[i];
      end
    end
  end

  // Request drops in the acknowledge cycle so it is never offered twice
  always_comb
  begin
    req_nxt.valid      = (take_hi | take_lo) & ~(req_r.valid & core_ack_i);
    req_nxt.high_level = take_hi;
    req_nxt.vector     = pick_vec;
  end

  assign core_req_o = req_r;
  wire   accept     = req_r.valid & core_ack_i;

  // --------------------------------------------------------------------------
  // In-service levels; a return with the flag still set re-requests
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      svc_low_r  <= 1'b0;
      svc_high_r <= 1'b0;
      req_r      <= '0;
    end
    else
    begin
      req_r <= req_nxt;
      if (accept && req_r.high_level)
        svc_high_r <= 1'b1;
      else if (ret_i && svc_high_r)
        svc_high_r <= 1'b0;
      if (accept && !req_r.high_level)
        svc_low_r <= 1'b1;
      else if (ret_i && !svc_high_r)
        svc_low_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Power modes and events
  // --------------------------------------------------------------------------
  // Wake from power-down needs only the port enable: the core is asleep
  wire pd_wake  = power_r[BIT_PDOWN_REQ] & |(port_active & port_en_r);
  wire idle_end = power_r[BIT_IDLE_REQ] & accept;

  always_comb
  begin
    power_nxt = wr_pwr ? wdata[1:0] : power_r;
    if (idle_end)
      power_nxt[BIT_IDLE_REQ] = 1'b0;
    if (pd_wake)
      power_nxt[BIT_PDOWN_REQ] = 1'b0;
  end

  // Sticky events: set wins over a write-one clear
  always_comb
  begin
    ev_stat_nxt = ev_stat_r & ~(wr_evs ? wdata[2:0] : 3'h0);
    ev_stat_nxt[BIT_EV_ACCEPT]   = ev_stat_nxt[BIT_EV_ACCEPT] | accept;
    ev_stat_nxt[BIT_EV_WAKE]     = ev_stat_nxt[BIT_EV_WAKE] | pd_wake;
    ev_stat_nxt[BIT_EV_IDLE_END] = ev_stat_nxt[BIT_EV_IDLE_END] | idle_end;
  end

  // Software register file
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      src_en_r   <= RST_REG8;
      port_en_r  <= RST_REG8;
      prio_lo_r  <= RST_REG8;
      prio_hi_r  <= RST_REG8;
      polarity_r <= RST_REG8;
      flags_r    <= RST_REG8;
      power_r    <= 2'h0;
      ev_stat_r  <= 3'h0;
      ev_mask_r  <= 3'h0;
    end
    else
    begin
      if (wr_src)
        src_en_r <= wdata & 8'h8f;
      if (wr_port)
        port_en_r <= wdata;
      if (wr_plo)
        prio_lo_r <= wdata & 8'h0f;
      if (wr_phi)
        prio_hi_r <= wdata;
      if (wr_pol)
        polarity_r <= wdata;
      if (wr_evm)
        ev_mask_r <= wdata[2:0];
      flags_r   <= flags_nxt;
      power_r   <= power_nxt;
      ev_stat_r <= ev_stat_nxt;
    end
  end

  assign idle_o      = power_r[BIT_IDLE_REQ];
  assign powerdown_o = power_r[BIT_PDOWN_REQ];
  assign wake_o      = pd_wake;
  assign irq_o       = |(ev_stat_r & ev_mask_r);

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_offer;
    req_r.valid && core_ack_i;
  endsequence

  sequence s_drop;
    !req_r.valid;
  endsequence

  AST_GLOBAL_GATE: assert property (@(posedge mclk_i) disable iff (srst_i)
    !src_en_r[BIT_GLOBAL_EN] |=> !req_r.valid)
    else $error("request offered with global enable cleared");

  AST_OWN_ENABLE: assert property (@(posedge mclk_i) disable iff (srst_i)
    req_r.valid && req_r.vector == 16'h0073 |-> $past(port_en_r[7]))
    else $error("port nine offered while disabled");

  AST_ACK_DROP: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_offer |=> s_drop)
    else $error("request not withdrawn after acknowledge");

  AST_NO_SAME_LEVEL: assert property (@(posedge mclk_i) disable iff (srst_i)
    svc_high_r |-> !req_r.valid)
    else $error("request during high-level service");

  AST_FLAG_STICKY: assert property (@(posedge mclk_i) disable iff (srst_i)
    !wr_flag |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("port flag cleared without a write");

  AST_LEVEL_SET: assert property (@(posedge mclk_i) disable iff (srst_i)
    sync_live && (pin_sync[0] == polarity_r[0]) |=> flags_r[0])
    else $error("active port level did not set its flag");

  AST_TOP_ORDER: assert property (@(posedge mclk_i) disable iff (srst_i)
    elig_hi[0] && !svc_high_r && !(req_r.valid && core_ack_i) |=> req_r.vector == 16'h0003)
    else $error("external zero not served first");

  AST_IDLE_END: assert property (@(posedge mclk_i) disable iff (srst_i)
    idle_o && accept && !wr_pwr |=> !idle_o ##0 ev_stat_r[BIT_EV_IDLE_END])
    else $error("accepted interrupt did not end idle");

  AST_WAKE: assert property (@(posedge mclk_i) disable iff (srst_i)
    pd_wake && !wr_pwr |=> !powerdown_o)
    else $error("enabled port request did not leave power-down");

  AST_RESET_CLEAR: assert property (@(posedge mclk_i)
    srst_i |=> flags_r == 8'h00 && src_en_r == 8'h00 && polarity_r == 8'h00)
    else $error("registers not cleared by reset");

endmodule : tsiu_top

`default_nettype wire

/* tb/tsiu_core_model.sv */
/*
  Core-side model: takes offered vectors after a chosen delay and
  returns from service when the bench asks for it.
  Assumes the unit's offer and the bench controls all run on mclk_i.
*/
`timescale 1ns/100ps
`default_nettype none

module tsiu_core_model
  import tsiu_pkg::*;
(
  // Clock and reset
  input  wire logic           mclk_i,
  input  wire logic           srst_i,
  // Offer from the unit
  input  wire tsiu_core_req_s core_req_i,
  // Bench controls
  input  wire logic [1:0]     ack_dly_i,
  input  wire logic           ret_go_i,
  // Answers to the unit
  output logic                core_ack_o,
  output logic                ret_o
);
  logic [1:0] wait_r;

  // Take an offer only while it is valid; one-cycle pulse, slow or prompt
  always_ff @(posedge mclk_i)
  begin
    if (srst_i || !core_req_i.valid || core_ack_o)
    begin
      wait_r     <= 2'h0;
      core_ack_o <= 1'b0;
    end
    else if (wait_r >= ack_dly_i)
      core_ack_o <= 1'b1;
    else
      wait_r <= wait_r + 2'h1;
  end

  // Return pulse; the bench clears port flags first unless it tests a re-raise
  always_ff @(posedge mclk_i)
    ret_o <= srst_i ? 1'b0 : ret_go_i;
endmodule : tsiu_core_model

`default_nettype wire

/* tb/tb_top.sv */
/*
  Self-checking bench of the interrupt unit: Avalon-MM tasks, source
  drivers and scenarios. Assumes the core model answers the offers.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import tsiu_pkg::*;
  logic           mclk_i = 1'b0;
  logic           srst_i = 1'b1;
  logic [7:0]     avs_address_i = 8'h0;
  logic           avs_read_i = 1'b0;
  logic           avs_write_i = 1'b0;
  logic [31:0]    avs_writedata_i = 32'h0;
  logic [31:0]    avs_readdata_o;
  logic           avs_waitrequest_o;
  logic           ext_zero_pending_i = 1'b0;
  logic           ext_request_one_i = 1'b0;
  logic           timer_zero_overflow_i = 1'b0;
  logic           timer_one_overflow_i = 1'b0;
  logic [7:0]     port_pin_i = 8'hff;
  tsiu_core_req_s core_req_o;
  logic           core_ack_i;
  logic           ret_i;
  logic           idle_o;
  logic           powerdown_o;
  logic           wake_o;
  logic           irq_o;
  logic [1:0]     ack_dly = 2'h0;
  logic           ret_go = 1'b0;
  logic [7:0]     pol = 8'h0;
  logic [15:0]    rq;
  logic [15:0]    v;
  logic           hl;
  logic [11:0]    m;
  int             seed = 32'h0827;
  int             error_cnt = 0;
  int             samples_checked = 0;
  int             k;
  // Source ids 0..3 ext0, timer0, ext1, timer1; 4..11 ports two..nine
  int             ord [12] = '{0, 7, 1, 8, 2, 4, 9, 3, 5, 10, 6, 11};
  logic [7:0]     ra [8] = '{IDX_PRIO_LOW, IDX_PORT_FLAGS, IDX_PORT_ENABLES, IDX_PORT_POLARITY,
                             IDX_PRIO_HIGH, IDX_SOURCE_ENABLES, IDX_POWER_CONTROL, IDX_EVENT_MASK};

  always #10 mclk_i = ~mclk_i;

  tsiu_top tsiu_top_inst (.mclk_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .ext_zero_pending_i,
    .ext_request_one_i, .timer_zero_overflow_i, .timer_one_overflow_i, .port_pin_i,
    .core_req_o, .core_ack_i, .ret_i, .idle_o, .powerdown_o, .wake_o, .irq_o);
  tsiu_core_model tsiu_core_model_inst (.mclk_i, .srst_i, .core_req_i(core_req_o),
    .ack_dly_i(ack_dly), .ret_go_i(ret_go), .core_ack_o(core_ack_i), .ret_o(ret_i));

  // ------------------------------------------------------------------
  // Expectations and drivers
  // ------------------------------------------------------------------
  // Legacy vectors step by 8 from 0003, ports carry on from 003b
  function automatic logic [15:0] vec(input int id);
    return 16'(3 + 8 * id + (id > 3 ? 24 : 0));
  endfunction : vec
  function automatic int first(input logic [11:0] e);
    for (int j = 0; j < 12; j++)
      if (e[ord[j]]) return ord[j];
    return 0;
  endfunction : first
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tmo();
    error_cnt++;
    $display("mismatch at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
    results();
  endtask : tmo
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_address_i   <= a;
    avs_read_i      <= ~w;
    avs_write_i     <= w;
    avs_writedata_i <= {24'h0, d};
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0) tmo();
    rq = avs_readdata_o[15:0];
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 8'h0);
    chk(rq, e);
  endtask : rc
  // Active level of a port pin is its polarity bit
  task automatic src(input logic [11:0] s);
    {timer_one_overflow_i, ext_request_one_i, timer_zero_overflow_i, ext_zero_pending_i} <= s[3:0];
    port_pin_i <= ~(pol ^ s[11:4]);
  endtask : src
  // Global enable off while the rest changes, so no half-set mix is ever offered
  task automatic cfg(input logic g, input logic [11:0] e, input logic [11:0] p);
    bus(1'b1, IDX_SOURCE_ENABLES, 8'h00);
    bus(1'b1, IDX_PORT_ENABLES, e[11:4]);
    bus(1'b1, IDX_PRIO_LOW, {4'h0, p[3:0]});
    bus(1'b1, IDX_PRIO_HIGH, p[11:4]);
    bus(1'b1, IDX_SOURCE_ENABLES, {g, 3'h0, e[3:0]});
  endtask : cfg
  task automatic clr();
    src(12'h0);
    repeat (4) @(posedge mclk_i);
    bus(1'b1, IDX_PORT_FLAGS, 8'h0);
  endtask : clr
  // Waits for an offer and for the core model to take it
  task automatic serve();
    int n;
    n = 0;
    do
    begin
      @(negedge mclk_i);
      n++;
    end
    while (core_req_o.valid !== 1'b1 && n < 40);
    if (core_req_o.valid !== 1'b1) tmo();
    while (core_ack_i !== 1'b1 && n < 80)
    begin
      @(negedge mclk_i);
      n++;
    end
    if (core_ack_i !== 1'b1) tmo();
    // The offer is not latched: what counts is the vector under the acknowledge
    v = core_req_o.vector;
    hl = core_req_o.high_level;
    @(posedge mclk_i);
  endtask : serve
  task automatic rtn();
    ret_go <= 1'b1;
    @(posedge mclk_i);
    ret_go <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask : rtn
  task automatic quiet(input int n);
    repeat (n)
    begin
      @(negedge mclk_i);
      chk(16'(core_req_o.valid), 16'h0);
    end
    @(posedge mclk_i);
  endtask : quiet

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge mclk_i);
    srst_i <= 1'b0;
    foreach (ra[j]) rc(ra[j], 16'h0);
    bus(1'b1, 8'h10, 8'h5a);
    rc(8'h10, 16'h0);
    repeat (4)
    begin
      m = 12'($random(seed));
      bus(1'b1, IDX_PORT_ENABLES, m[7:0]);
      rc(IDX_PORT_ENABLES, {8'h0, m[7:0]});
      bus(1'b1, IDX_PRIO_HIGH, m[11:4]);
      rc(IDX_PRIO_HIGH, {8'h0, m[11:4]});
    end
    bus(1'b1, IDX_PRIO_LOW, 8'hff);
    rc(IDX_PRIO_LOW, 16'h000f);
    bus(1'b1, IDX_SOURCE_ENABLES, 8'hff);
    rc(IDX_SOURCE_ENABLES, 16'h008f);
    $display("test registers done, mismatches %0d", error_cnt);
    cfg(1'b0, 12'h0, 12'h0);
    pol = 8'($random(seed));
    src(12'h0);
    bus(1'b1, IDX_PORT_POLARITY, pol);
    clr();
    for (k = 0; k < 8; k++)
    begin
      src(12'h10 << k);
      repeat (4) @(posedge mclk_i);
      bus(1'b1, IDX_PORT_FLAGS, 8'h0);
      rc(IDX_PORT_FLAGS, 16'h1 << k);
      src(12'h0);
      repeat (4) @(posedge mclk_i);
      rc(IDX_PORT_FLAGS, 16'h1 << k);
      bus(1'b1, IDX_PORT_FLAGS, 8'h0);
      rc(IDX_PORT_FLAGS, 16'h0);
    end
    $display("test levels done, mismatches %0d", error_cnt);
    cfg(1'b0, 12'hfff, 12'h0);
    src(12'hfff);
    quiet(12);
    cfg(1'b1, 12'h0, 12'h0);
    quiet(12);
    cfg(1'b1, 12'hfff, 12'h0);
    m = 12'hfff;
    for (k = 0; k < 12; k++)
    begin
      ack_dly <= 2'($random(seed));
      serve();
      chk(v, vec(ord[k]));
      chk(16'(hl), 16'h0);
      m[ord[k]] = 1'b0;
      src(m);
      repeat (4) @(posedge mclk_i);
      if (k == 1)
      begin
        rtn();
        serve();
        chk(v, vec(ord[1]));
      end
      bus(1'b1, IDX_PORT_FLAGS, 8'h0);
      rtn();
    end
    $display("test order done, mismatches %0d", error_cnt);
    // Slow acknowledge lets synchronised port flags overtake an early legacy offer
    ack_dly <= 2'h3;
    repeat (6)
    begin
      m = 12'($random(seed));
      if (m == 12'h0) m = 12'h800;
      cfg(1'b1, m, 12'h0);
      src(12'hfff);
      serve();
      chk(v, vec(first(m)));
      clr();
      rtn();
    end
    $display("test enables done, mismatches %0d", error_cnt);
    repeat (4)
    begin
      k = 1 + (($random(seed) & 32'hff) % 11);
      cfg(1'b1, 12'hfff, 12'h1 << k);
      src(12'h1);
      serve();
      chk(v, vec(0));
      src(12'hfff);
      serve();
      chk(v, vec(k));
      chk(16'(hl), 16'h1);
      quiet(10);
      clr();
      rtn();
      rtn();
    end
    $display("test preempt done, mismatches %0d", error_cnt);
    cfg(1'b1, 12'h1, 12'h1);
    bus(1'b1, IDX_EVENT_STATUS, 8'hff);
    bus(1'b1, IDX_EVENT_MASK, 8'h01);
    bus(1'b1, IDX_POWER_CONTROL, 8'h01);
    @(negedge mclk_i);
    chk(16'({idle_o, irq_o}), 16'h2);
    @(posedge mclk_i);
    src(12'h1);
    serve();
    src(12'h0);
    rc(IDX_EVENT_STATUS, 16'h5);
    @(negedge mclk_i);
    chk(16'({idle_o, irq_o}), 16'h1);
    bus(1'b1, IDX_EVENT_MASK, 8'h0);
    @(negedge mclk_i);
    chk(16'(irq_o), 16'h0);
    bus(1'b1, IDX_EVENT_MASK, 8'h05);
    bus(1'b1, IDX_EVENT_STATUS, 8'h05);
    @(negedge mclk_i);
    chk(16'(irq_o), 16'h0);
    rtn();
    $display("test events done, mismatches %0d", error_cnt);
    cfg(1'b0, 12'h10, 12'h0);
    bus(1'b1, IDX_POWER_CONTROL, 8'h02);
    src(12'h20);
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(16'({powerdown_o, wake_o}), 16'h2);
    @(posedge mclk_i);
    src(12'h10);
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(16'({powerdown_o, wake_o}), 16'h3);
    @(posedge mclk_i);
    @(negedge mclk_i);
    chk(16'({powerdown_o, wake_o}), 16'h0);
    @(posedge mclk_i);
    clr();
    rc(IDX_EVENT_STATUS, 16'h2);
    $display("test powerdown done, mismatches %0d", error_cnt);
    results();
  end
endmodule : tb_top

`default_nettype wire
